// ==== rtl/irc_receive.sv ====
// Infrared receive capture timer with burst-count mode and a plain register port.
`timescale 1ns/10ps
module irc_receive (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic RECEIVE_PIN,
    output logic [15:0] RDATA,
    output logic IRQ
);
    import irc_pkg::*;

    irc_state_s r;
    irc_state_s next_r;
    irc_req_s req;

    // Bundle the register port.
    always_comb begin
        req.addr = ADDR;
        req.wdata = WDATA;
        req.wr = WR;
        req.rd = RD;
    end

    // Decoded control fields.
    logic enable;
    logic tx_sel;
    logic [1:0] edge_sel;
    logic clk_src;
    logic reload;
    logic burst;
    logic irq_en;
    logic [1:0] div_sel;
    assign enable = r.ctrl[CTRL_ENABLE];
    assign tx_sel = r.ctrl[CTRL_TX_SELECT];
    assign edge_sel = r.ctrl[CTRL_EDGE_LO +: 2];
    assign clk_src = r.ctrl[CTRL_CLK_SRC];
    assign reload = r.ctrl[CTRL_RELOAD];
    assign burst = r.ctrl[CTRL_BURST];
    assign irq_en = r.ctrl[CTRL_IRQ_EN];
    assign div_sel = r.ctrl[CTRL_DIV_LO +: 2];

    // Combinational helpers.
    logic rx_on;
    logic rise;
    logic fall;
    logic qual;
    logic ir_tick;
    logic carrier_tick;
    logic count_tick;
    logic [3:0] div_len;
    logic wr_ctrl;
    logic wr_status;
    logic wr_counter;
    logic burst_on_edge;

    // Receive mode is active only with the unit on and transmit deselected.
    // receive mode gate
    assign rx_on = enable && !tx_sel;

    // Edges come from the second synchroniser stage only, never the first.
    // two-flop synchroniser edges
    assign rise = r.sync2 && !r.pin_prev;
    assign fall = !r.sync2 && r.pin_prev;

    always_comb begin
        case (irc_edge_e'(edge_sel))
            IRC_EDGE_RISE: qual = rise;
            IRC_EDGE_FALL: qual = fall;
            default: qual = rise || fall;
        endcase
    end

    // Divider length 1, 2, 4 or 8 system clocks per infrared clock.
    // infrared clock divider
    // The prescaler runs from one up to the length; for eight it wraps through zero.
    assign div_len = 4'h1 << div_sel;
    assign ir_tick = rx_on && (r.prescale == div_len[2:0]);

    // A carrier cycle ends at the last infrared clock of the low phase.
    // carrier cycle end
    assign carrier_tick = ir_tick && (r.phase == IRC_PH_LOW)
        && (r.phase_cnt == r.carrier[7:0]);

    assign count_tick = clk_src ? ir_tick : carrier_tick;

    assign wr_ctrl = req.wr && (req.addr == ADDR_CTRL);
    assign wr_status = req.wr && (req.addr == ADDR_STATUS);
    assign wr_counter = req.wr && (req.addr == ADDR_COUNTER);
    assign burst_on_edge = wr_ctrl && !burst && req.wdata[CTRL_BURST];

    // Next-state logic for the whole block; hardware sets beat software clears.
    always_comb begin
        next_r = r;
        next_r.sync1 = RECEIVE_PIN;
        next_r.sync2 = r.sync1;
        next_r.pin_prev = r.sync2;
        next_r.rdata = 16'h0000;

        // Software writes come first so hardware events below override them, except the count step, which a counter write suppresses.
        if (wr_ctrl) begin
            next_r.ctrl = req.wdata;
        end
        if (req.wr && (req.addr == ADDR_CARRIER)) begin
            next_r.carrier = req.wdata;
        end
        if (wr_counter) begin
            next_r.counter = req.wdata;
        end
        if (req.wr && (req.addr == ADDR_MODTIME)) begin
            next_r.modtime = req.wdata;
        end
        if (wr_status) begin
            next_r.overflow = r.overflow && req.wdata[STAT_OVERFLOW];
            next_r.rx_event = r.rx_event && req.wdata[STAT_RX_EVENT];
        end
        // Prescaler and carrier phase run only in receive mode.
        if (!rx_on) begin
            next_r.prescale = PRE_ONE;
            next_r.phase = IRC_PH_HIGH;
            next_r.phase_cnt = BYTE_ZERO;
            next_r.state = IRC_IDLE;
            next_r.space_cnt = 2'h0;
            next_r.space_seen = 1'b0;
        end else begin
            next_r.prescale = ir_tick ? PRE_ONE : r.prescale + PRE_ONE;
            if (r.state == IRC_IDLE) begin
                next_r.state = IRC_ARMED;
            end
            if (ir_tick) begin
                if (r.phase == IRC_PH_HIGH && r.phase_cnt == r.carrier[15:8]) begin
                    next_r.phase = IRC_PH_LOW;
                    next_r.phase_cnt = BYTE_ZERO;
                end else if (carrier_tick) begin
                    next_r.phase = IRC_PH_HIGH;
                    next_r.phase_cnt = BYTE_ZERO;
                end else begin
                    next_r.phase_cnt = r.phase_cnt + BYTE_ONE;
                end
            end
        end

        case (r.state)
            IRC_ARMED: begin
                if (rx_on && qual) begin
                    next_r.state = IRC_RUN;
                    next_r.counter = COUNT_ZERO;
                end
            end
            IRC_RUN: begin
                if (rx_on) begin
                    if (count_tick) begin
                        // A software write to the counter wins over the count step.
                        if (!wr_counter) begin
                            next_r.counter = r.counter + COUNT_ONE;
                        end
                        if (r.counter == 16'hFFFF && !qual) begin
                            next_r.overflow = 1'b1;
                        end
                    end
                    if (qual) begin
                        next_r.level = r.sync2;
                        if (reload) begin
                            next_r.counter = COUNT_ZERO;
                        end
                        if (!burst) begin
                            next_r.modtime = r.counter;
                            next_r.rx_event = 1'b1;
                        end else if (!burst_on_edge) begin
                            next_r.modtime = r.modtime + COUNT_ONE;
                        end
                        next_r.space_cnt = 2'h0;
                        next_r.space_seen = 1'b0;
                    end else if (burst && carrier_tick && !r.space_seen) begin
                        if (r.space_cnt + 2'h1 == SPACE_CYCLES) begin
                            next_r.rx_event = 1'b1;
                            next_r.space_seen = 1'b1;
                            next_r.space_cnt = 2'h0;
                        end else begin
                            next_r.space_cnt = r.space_cnt + 2'h1;
                        end
                    end
                end
            end
            IRC_IDLE: begin
                next_r.space_cnt = 2'h0;
            end
            default: begin
                next_r.state = IRC_IDLE;
            end
        endcase

        // burst entry load
        // Applied last, so a capture in the same cycle cannot hide the load.
        if (burst_on_edge) begin
            next_r.modtime = MODTIME_BURST_LOAD;
        end

        next_r.irq = irq_en && (next_r.overflow || next_r.rx_event);

        // Read data appears in the cycle after the read strobe.
        if (req.rd) begin
            case (req.addr)
                ADDR_CTRL: next_r.rdata = r.ctrl;
                ADDR_CARRIER: next_r.rdata = r.carrier;
                ADDR_COUNTER: next_r.rdata = r.counter;
                ADDR_MODTIME: next_r.rdata = r.modtime;
                ADDR_STATUS: next_r.rdata = {13'h0000, r.level, r.rx_event, r.overflow};
                default: next_r.rdata = 16'h0000;
            endcase
        end
    end

    // State register.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            r <= '0;
            r.ctrl <= CTRL_RESET;
            r.carrier <= CARRIER_RESET;
            r.prescale <= PRE_ONE;
        end else begin
            r <= next_r;
        end
    end

    assign RDATA = r.rdata;
    assign IRQ = r.irq;

    // Assertions.
    sequence s_armed_edge;
        r.state == IRC_ARMED && rx_on && qual;
    endsequence

    // The second edgeless carrier cycle of a space in burst-count mode.
    sequence s_second_idle_cycle;
        r.state == IRC_RUN && rx_on && burst && carrier_tick && !qual
            && !r.space_seen && r.space_cnt == 2'h1;
    endsequence

    a_first_edge_start: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_armed_edge |=> (r.state == IRC_RUN && r.counter == COUNT_ZERO))
        else $error("Counter did not start from zero at first edge.");

    a_capture_counter: assert property (@(posedge CORE_CLK) disable iff (RST)
        (r.state == IRC_RUN && rx_on && qual && !burst && !wr_ctrl
         && !(req.wr && req.addr == ADDR_MODTIME)) |=> r.modtime == $past(r.counter))
        else $error("Counter value not captured.");

    a_capture_level: assert property (@(posedge CORE_CLK) disable iff (RST)
        (r.state == IRC_RUN && rx_on && qual) |=> r.level == $past(r.sync2))
        else $error("Pin level not captured.");

    a_capture_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
        (r.state == IRC_RUN && rx_on && qual && !burst) |=> r.rx_event)
        else $error("Capture did not set the receive flag.");

    a_reload_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
        (r.state == IRC_RUN && rx_on && qual && reload && !wr_ctrl
         && !wr_counter) |=> r.counter == COUNT_ZERO)
        else $error("Counter not reloaded on capture.");

    a_overflow_set: assert property (@(posedge CORE_CLK) disable iff (RST)
        (r.state == IRC_RUN && rx_on && count_tick && r.counter == 16'hFFFF && !qual)
        |=> r.overflow)
        else $error("Wrap did not set overflow.");

    a_burst_load: assert property (@(posedge CORE_CLK) disable iff (RST)
        burst_on_edge |=> r.modtime == MODTIME_BURST_LOAD)
        else $error("Burst entry did not load one.");

    a_burst_edge_count: assert property (@(posedge CORE_CLK) disable iff (RST)
        (r.state == IRC_RUN && rx_on && qual && burst)
        |=> r.modtime == $past(r.modtime) + COUNT_ONE)
        else $error("Burst edge not counted.");

    a_space_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_second_idle_cycle |=> r.rx_event)
        else $error("Space after two idle carrier cycles not flagged.");

    a_stop_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
        (enable && tx_sel) |=> r.state == IRC_IDLE)
        else $error("Receive continued in transmit mode.");

    a_ir_divide: assert property (@(posedge CORE_CLK) disable iff (RST)
        (ir_tick && div_sel == 2'h1 && !wr_ctrl) |=> !ir_tick)
        else $error("Infrared clock ran faster than the divider allows.");

    a_irq_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
        !irq_en |=> !IRQ)
        else $error("Interrupt raised while disabled.");

    a_irq_raise: assert property (@(posedge CORE_CLK) disable iff (RST)
        (irq_en && (r.overflow || r.rx_event) && !wr_status) |=> IRQ)
        else $error("Interrupt missing with a flag set and enabled.");
endmodule

// ==== rtl/irc_pkg.sv ====
// Package holding register map, field layout and state types of the infrared receive capture block.
package irc_pkg;
    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CARRIER = 4'h1;
    localparam logic [3:0] ADDR_COUNTER = 4'h2;
    localparam logic [3:0] ADDR_MODTIME = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    // Control register field positions.
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_TX_SELECT = 1;
    localparam int CTRL_EDGE_LO = 2;
    localparam int CTRL_CLK_SRC = 4;
    localparam int CTRL_RELOAD = 5;
    localparam int CTRL_BURST = 6;
    localparam int CTRL_IRQ_EN = 7;
    localparam int CTRL_DIV_LO = 8;
    // Status register field positions.
    localparam int STAT_OVERFLOW = 0;
    localparam int STAT_RX_EVENT = 1;
    localparam int STAT_LEVEL = 2;
    // Reset values, the burst load value and count steps.
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CARRIER_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] MODTIME_BURST_LOAD = 16'h0001;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [2:0] PRE_ONE = 3'h1;
    // Carrier cycles without an edge that mark the start of a space.
    localparam logic [1:0] SPACE_CYCLES = 2'h2;

    // Edge selection encodings.
    typedef enum logic [1:0] {
        IRC_EDGE_RISE = 2'b00,
        IRC_EDGE_FALL = 2'b01,
        IRC_EDGE_BOTH = 2'b10,
        IRC_EDGE_BOTH2 = 2'b11
    } irc_edge_e;

    // Receive sequencing.
    typedef enum logic [1:0] {
        IRC_IDLE = 2'b00,
        IRC_ARMED = 2'b01,
        IRC_RUN = 2'b10
    } irc_state_e;

    // Carrier phase.
    typedef enum logic [0:0] {
        IRC_PH_HIGH = 1'b0,
        IRC_PH_LOW = 1'b1
    } irc_phase_e;

    // Register port request.
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } irc_req_s;

    // All state of the block.
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] carrier;
        logic [15:0] counter;
        logic [15:0] modtime;
        logic [15:0] rdata;
        logic [2:0] prescale;
        logic [7:0] phase_cnt;
        irc_phase_e phase;
        irc_state_e state;
        logic [1:0] space_cnt;
        logic space_seen;
        logic overflow;
        logic rx_event;
        logic level;
        logic irq;
        logic sync1;
        logic sync2;
        logic pin_prev;
    } irc_state_s;
endpackage

// ==== test/irc_ir_sender.sv ====
// Behavioural infrared receiver that drives the demodulated level onto the receive pin.
`timescale 1ns/10ps
module irc_ir_sender (
    input wire logic clk,
    output logic pin
);
    // The receiver output is a plain push-pull level, so it always shows a defined value.
    initial begin
        pin = 1'b0;
    end

    // Puts a level on the pin just after an edge and keeps it for the given number of cycles.
    task automatic hold(input logic lvl, input int cycles);
        @(posedge clk);
        pin <= lvl;
        repeat (cycles) @(posedge clk);
    endtask
endmodule

// ==== test/tb_ir_receive_capture.sv ====
// Self-checking testbench of the infrared receive capture block.
`timescale 1ns/10ps
module tb_ir_receive_capture;
    import irc_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rx_pin;
    logic [15:0] rdata;
    logic irq;
    logic [15:0] rv;
    int failures = 0;
    int checks_done = 0;

    irc_ir_sender u_rx (.clk(core_clk), .pin(rx_pin));

    irc_receive u_dut (.CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RECEIVE_PIN(rx_pin), .RDATA(rdata), .IRQ(irq));

    // Free-running 250 MHz core clock.
    always #2 core_clk = ~core_clk;

    // Control word: enabled, receive, interrupt enable, chosen edge, source and reload.
    function automatic logic [15:0] ctl(input logic [1:0] e, input logic src, input logic rl);
        ctl = 16'h0001 | ({14'h0000, e} << CTRL_EDGE_LO) | (16'(src) << CTRL_CLK_SRC)
            | (16'(rl) << CTRL_RELOAD) | (16'h0001 << CTRL_IRQ_EN);
    endfunction

    // Register write: one strobe cycle.
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    // Register read: data stands only in the cycle after the strobe.
    task automatic rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Stops the unit, parks the pin, clears flags, restarts and plays a train of edges.
    task automatic pulses(input logic [15:0] c, input logic start, input int n, input int gap);
        logic lvl;
        wreg(ADDR_CTRL, 16'h0000);
        u_rx.hold(start, 8);
        wreg(ADDR_STATUS, 16'h0000);
        wreg(ADDR_CTRL, c);
        repeat (4) @(posedge core_clk);
        lvl = start;
        for (int i = 0; i < n; i++) begin
            lvl = ~lvl;
            u_rx.hold(lvl, gap);
        end
        repeat (8) @(posedge core_clk);
    endtask

    task automatic summarize();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog that cuts a hung run short.
    initial begin
        repeat (100000) @(posedge core_clk);
        failures++;
        summarize();
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rreg(ADDR_CTRL, rv); check(rv, CTRL_RESET);
        rreg(ADDR_STATUS, rv); check(rv, 16'h0000);
        rreg(4'hF, rv); check(rv, 16'h0000);
        wreg(4'hF, 16'hFFFF);
        wreg(ADDR_CARRIER, 16'h0303);
        rreg(ADDR_CARRIER, rv); check(rv, 16'h0303);
        // Every edge code; the last code also runs with reload off so the counter keeps going.
        // Edges stand 11 clocks apart, so a capture holds the interval in clocks minus one.
        for (int e = 0; e < 4; e++) begin
            pulses(ctl(e[1:0], 1'b1, e != 3), e == 1, 3, 10);
            rreg(ADDR_MODTIME, rv); check(rv, (e == 2) ? 16'h000A : 16'h0015);
            rreg(ADDR_STATUS, rv); check(rv & 16'h0007, (e == 1) ? 16'h0002 : 16'h0006);
            check({15'h0000, irq}, 16'h0001);
        end
        // Clearing the flags by writing zero drops the request.
        wreg(ADDR_STATUS, 16'h0000);
        repeat (3) @(posedge core_clk);
        #1;
        check({15'h0000, irq}, 16'h0000);
        // Carrier-cycle source: 8 clocks per carrier cycle, 81 clocks between edges.
        pulses(ctl(2'h2, 1'b0, 1'b1), 1'b0, 2, 80);
        rreg(ADDR_MODTIME, rv); check(rv, 16'h000A);
        // Infrared clock divided by two: 41 clocks between edges.
        pulses(ctl(2'h2, 1'b1, 1'b1) | 16'h0100, 1'b0, 2, 40);
        rreg(ADDR_MODTIME, rv); check(rv, 16'h0014);
        // Transmit selected, then unit disabled: edges are not captured.
        pulses(ctl(2'h2, 1'b1, 1'b1) | 16'h0002, 1'b0, 3, 10);
        rreg(ADDR_STATUS, rv); check(rv & 16'h0002, 16'h0000);
        pulses(ctl(2'h2, 1'b1, 1'b1) & 16'hFFFE, 1'b0, 3, 10);
        rreg(ADDR_STATUS, rv); check(rv & 16'h0002, 16'h0000);
        // Counter wrap with no edge sets overflow; the request follows the enable bit.
        pulses(ctl(2'h2, 1'b1, 1'b1), 1'b0, 1, 4);
        wreg(ADDR_STATUS, 16'h0000);
        wreg(ADDR_COUNTER, 16'hFFF0);
        repeat (30) @(posedge core_clk);
        rreg(ADDR_STATUS, rv); check(rv & 16'h0003, 16'h0001);
        check({15'h0000, irq}, 16'h0001);
        wreg(ADDR_CTRL, ctl(2'h2, 1'b1, 1'b1) & ~(16'h0001 << CTRL_IRQ_EN));
        repeat (3) @(posedge core_clk);
        #1;
        check({15'h0000, irq}, 16'h0000);
        rreg(ADDR_STATUS, rv); check(rv & 16'h0001, 16'h0001);
        // Burst-count mode: load of one, edge counting, then a space after the carrier stops.
        pulses(ctl(2'h2, 1'b1, 1'b1), 1'b0, 1, 4);
        wreg(ADDR_CTRL, ctl(2'h2, 1'b1, 1'b1) | 16'h0040);
        rreg(ADDR_MODTIME, rv); check(rv, MODTIME_BURST_LOAD);
        wreg(ADDR_STATUS, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            // The pin stands high here, so the first level is low and all five are edges.
            u_rx.hold(i[0] == 1'b1, 3);
        end
        repeat (4) @(posedge core_clk);
        rreg(ADDR_MODTIME, rv); check(rv, 16'h0006);
        rreg(ADDR_STATUS, rv); check(rv & 16'h0002, 16'h0000);
        repeat (40) @(posedge core_clk);
        rreg(ADDR_STATUS, rv); check(rv & 16'h0002, 16'h0002);
        summarize();
    end
endmodule
